// ### design/lpd_map.svh
// Command codes, widths, burst length codes and default counts of the device end
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH
`define LPD_CA_W 10
`define LPD_DQ_W 16
`define LPD_MASK_W 2
`define LPD_BANKS 4
`define LPD_ROW_W 13
`define LPD_COL_W 9
`define LPD_MEM_AW 8
`define LPD_SYNC_W 34
`define LPD_OP_ACT 4'h1
`define LPD_OP_WR 4'h2
`define LPD_OP_WRA 4'h3
`define LPD_OP_RD 4'h4
`define LPD_OP_RDA 4'h5
`define LPD_OP_PRE 4'h6
`define LPD_OP_PREA 4'h7
`define LPD_OP_REFA 4'h8
`define LPD_OP_SREF 4'h9
`define LPD_OP_DEEP 4'ha
`define LPD_BL4 2'h1
`define LPD_BL8 2'h2
`define LPD_BL16 2'h3
`define LPD_BEATS4 5'h04
`define LPD_BEATS8 5'h08
`define LPD_BEATS16 5'h10
`endif

// ### design/lpd_pkg.sv
// Types shared by the device end
package lpd_pkg;
    typedef enum logic [1:0] {lpd_pwr_active, lpd_pwr_down, lpd_pwr_self_refresh,
        lpd_pwr_deep_sleep} lpd_pwr_e;
    typedef enum logic [1:0] {lpd_bst_idle, lpd_bst_wait, lpd_bst_read,
        lpd_bst_write} lpd_bst_e;
endpackage : lpd_pkg

// ### design/lpd_device.sv
// Device end of the command/address and data interface, with a small backing store
`timescale 1ns/1ps
`include "lpd_map.svh"

module lpd_device
    import lpd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clock_true_input,
    input wire logic clock_complement_input,
    input wire logic cs_n,
    input wire logic cke,
    input wire logic [`LPD_CA_W-1:0] cmd_addr_bus,
    input wire logic [`LPD_DQ_W-1:0] dq_in,
    output logic [`LPD_DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic strobe_true_in,
    input wire logic strobe_comp_in,
    output logic strobe_true_out,
    output logic strobe_comp_out,
    output logic strobe_oe,
    input wire logic [`LPD_MASK_W-1:0] write_byte_mask,
    input wire logic [1:0] burst_len_code,
    input wire logic [3:0] read_delay_cycles,
    input wire logic [3:0] write_delay_cycles,
    input wire logic [`LPD_BANKS-1:0] partial_array_self_refresh,
    output logic [`LPD_BANKS-1:0] bank_open,
    output logic [`LPD_BANKS-1:0] banks_retained,
    output logic in_power_down,
    output logic in_self_refresh,
    output logic in_deep_sleep,
    output logic refresh_done
);
    // ==========================================================
    // Pin synchroniser: three stages, a change counts when 2 and 3 agree
    logic [`LPD_SYNC_W-1:0] sync1, sync2, sync3, pins, raw;

    assign raw = {clock_true_input, clock_complement_input, cs_n, cke, cmd_addr_bus,
        strobe_true_in, strobe_comp_in, dq_in, write_byte_mask};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pins <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pins <= (sync2 & sync3) | (pins & (sync2 ^ sync3));
        end
    end

    logic f_ck_t, f_ck_c, f_cs_n, f_cke, f_dqs_t;
    logic [`LPD_CA_W-1:0] f_ca;
    logic [`LPD_DQ_W-1:0] f_dq;
    logic [`LPD_MASK_W-1:0] f_dm;
    assign {f_ck_t, f_ck_c, f_cs_n, f_cke, f_ca, f_dqs_t} = pins[`LPD_SYNC_W-1:19];
    assign f_dq = pins[17:2];
    assign f_dm = pins[1:0];

    // ==========================================================
    // Link clock edges from the differential crossing
    logic ck_rise_state, ck_fall_state, ck_last_rise, link_rise, link_fall, dqs_last, dqs_edge;

    assign ck_rise_state = f_ck_t & ~f_ck_c;
    assign ck_fall_state = ~f_ck_t & f_ck_c;
    assign link_rise = ck_rise_state & ~ck_last_rise;
    assign link_fall = ck_fall_state & ck_last_rise;
    assign dqs_edge = f_dqs_t ^ dqs_last;

    // A stopped link clock simply yields no edges, so only a write burst, clocked by the strobe, advances
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ck_last_rise <= 1'b0;
            dqs_last <= 1'b0;
        end else begin
            if (ck_rise_state) begin
                ck_last_rise <= 1'b1;
            end else if (ck_fall_state) begin
                ck_last_rise <= 1'b0;
            end
            dqs_last <= f_dqs_t;
        end
    end

    // ==========================================================
    // Command capture and power state
    lpd_pwr_e pwr;
    logic cke_prev, cmd_half, cmd_valid;
    logic [`LPD_CA_W-1:0] ca_rise, ca_fall;
    logic [3:0] opcode;
    logic [1:0] cmd_bank;

    assign opcode = ca_rise[3:0];
    assign cmd_bank = ca_rise[5:4];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_half <= 1'b0;
            ca_rise <= '0;
            ca_fall <= '0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            if (link_rise) begin
                // Chip select and clock enable are looked at on the rising edge only
                cmd_half <= ~f_cs_n & f_cke & (pwr == lpd_pwr_active);
                ca_rise <= f_ca;
            end else if (link_fall && cmd_half) begin
                ca_fall <= f_ca;
                cmd_half <= 1'b0;
                cmd_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pwr <= lpd_pwr_active;
            cke_prev <= 1'b1;
        end else if (link_rise) begin
            cke_prev <= f_cke;
            if (cke_prev && !f_cke && pwr == lpd_pwr_active) begin
                if (!f_cs_n && f_ca[3:0] == `LPD_OP_SREF) begin
                    pwr <= lpd_pwr_self_refresh;
                end else if (!f_cs_n && f_ca[3:0] == `LPD_OP_DEEP) begin
                    pwr <= lpd_pwr_deep_sleep;
                end else begin
                    pwr <= lpd_pwr_down;
                end
            end else if (!cke_prev && f_cke) begin
                pwr <= lpd_pwr_active;
            end
        end
    end

    assign in_power_down = (pwr == lpd_pwr_down);
    assign in_self_refresh = (pwr == lpd_pwr_self_refresh);
    assign in_deep_sleep = (pwr == lpd_pwr_deep_sleep);

    // ==========================================================
    // Bank state
    logic [`LPD_ROW_W-1:0] open_row [0:`LPD_BANKS-1];
    logic auto_pre;
    logic [1:0] acc_bank;
    logic burst_done;
    logic is_access;

    assign is_access = cmd_valid && opcode >= `LPD_OP_WR && opcode <= `LPD_OP_RDA;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bank_open <= '0;
            refresh_done <= 1'b0;
            banks_retained <= '1;
            for (int b = 0; b < `LPD_BANKS; b++) begin
                open_row[b] <= '0;
            end
        end else begin
            refresh_done <= 1'b0;
            if (pwr == lpd_pwr_deep_sleep) begin
                bank_open <= '0;
                banks_retained <= '0;
            end else if (pwr == lpd_pwr_self_refresh) begin
                banks_retained <= ~partial_array_self_refresh;
            end else if (cmd_valid) begin
                unique case (opcode)
                    `LPD_OP_ACT: begin
                        bank_open[cmd_bank] <= 1'b1;
                        open_row[cmd_bank] <= {ca_rise[9:6], ca_fall[8:0]};
                    end
                    `LPD_OP_PRE: bank_open[cmd_bank] <= 1'b0;
                    `LPD_OP_PREA: bank_open <= '0;
                    `LPD_OP_REFA: refresh_done <= (bank_open == '0);
                    default: ;
                endcase
            end
            if (burst_done && auto_pre) begin
                bank_open[acc_bank] <= 1'b0;
            end
            if (pwr == lpd_pwr_active) begin
                banks_retained <= '1;
            end
        end
    end

    // ==========================================================
    // Burst engine
    lpd_bst_e bst;
    logic is_read;
    logic [3:0] delay_left;
    logic [4:0] beats_left, beat, beats_total;
    logic [`LPD_COL_W-1:0] start_col, beat_col;
    logic [1:0] acc_row_lo;
    logic [`LPD_MEM_AW-1:0] mem_addr;
    logic [`LPD_DQ_W-1:0] mem [0:(1<<`LPD_MEM_AW)-1];
    logic accepted;

    always_comb begin
        unique case (burst_len_code)
            `LPD_BL8: beats_total = `LPD_BEATS8;
            `LPD_BL16: beats_total = `LPD_BEATS16;
            default: beats_total = `LPD_BEATS4;
        endcase
    end

    // Wrap within the burst; start column always even
    assign beat_col = (start_col & ~{4'h0, beats_total - 5'h01})
        | ((start_col + {4'h0, beat}) & {4'h0, beats_total - 5'h01});
    assign mem_addr = {acc_bank, acc_row_lo, beat_col[3:0]};
    // Access to a closed bank is the controller's fault; the command is dropped
    assign accepted = is_access && bank_open[cmd_bank] && bst == lpd_bst_idle;
    assign burst_done = (bst == lpd_bst_read || bst == lpd_bst_write)
        && beats_left == 5'h01
        && ((bst == lpd_bst_read && (link_rise || link_fall)) || (bst == lpd_bst_write
        && dqs_edge));

    always_ff @(posedge sys_clk) begin
        if (rst || pwr == lpd_pwr_deep_sleep) begin
            bst <= lpd_bst_idle;
            is_read <= 1'b0;
            auto_pre <= 1'b0;
            acc_bank <= '0;
            acc_row_lo <= '0;
            start_col <= '0;
            delay_left <= '0;
            beats_left <= '0;
            beat <= '0;
        end else begin
            unique case (bst)
                lpd_bst_idle: if (accepted) begin
                    is_read <= (opcode == `LPD_OP_RD || opcode == `LPD_OP_RDA);
                    auto_pre <= (opcode == `LPD_OP_WRA || opcode == `LPD_OP_RDA);
                    acc_bank <= cmd_bank;
                    acc_row_lo <= open_row[cmd_bank][1:0];
                    start_col <= {ca_fall[7:0], 1'b0};
                    delay_left <= (opcode == `LPD_OP_RD || opcode == `LPD_OP_RDA)
                        ? read_delay_cycles : write_delay_cycles;
                    beats_left <= beats_total;
                    beat <= '0;
                    bst <= lpd_bst_wait;
                end
                lpd_bst_wait: if (link_rise) begin
                    if (delay_left <= 4'h1) begin
                        bst <= is_read ? lpd_bst_read : lpd_bst_write;
                    end else begin
                        delay_left <= delay_left - 4'h1;
                    end
                end
                lpd_bst_read: if (link_rise || link_fall) begin
                    beat <= beat + 5'h01;
                    beats_left <= beats_left - 5'h01;
                    if (beats_left == 5'h01) begin
                        bst <= lpd_bst_idle;
                    end
                end
                lpd_bst_write: if (dqs_edge) begin
                    beat <= beat + 5'h01;
                    beats_left <= beats_left - 5'h01;
                    if (beats_left == 5'h01) begin
                        bst <= lpd_bst_idle;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Data path: write with byte mask, read with edge-aligned strobe
    always_ff @(posedge sys_clk) begin
        if (bst == lpd_bst_write && dqs_edge) begin
            for (int i = 0; i < `LPD_MASK_W; i++) begin
                if (!f_dm[i]) begin
                    mem[mem_addr][i*8 +: 8] <= f_dq[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dq_out <= '0;
            strobe_true_out <= 1'b1;
        end else if (bst == lpd_bst_read && (link_rise || link_fall)) begin
            dq_out <= mem[mem_addr];
            strobe_true_out <= link_rise;
        end else if (bst != lpd_bst_read) begin
            // Idle high: the first beat lands on a falling link edge and must still toggle
            strobe_true_out <= 1'b1;
        end
    end

    assign strobe_comp_out = ~strobe_true_out;

    // Drivers only while a read burst is running and clock enable stays high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dq_oe <= 1'b0;
            strobe_oe <= 1'b0;
        end else begin
            dq_oe <= bst == lpd_bst_read && f_cke;
            strobe_oe <= bst == lpd_bst_read && f_cke;
        end
    end

endmodule : lpd_device

// ### bench/lpd_sva.sv
// Port-level assertions for the device end of the command and data interface
`timescale 1ns/1ps
`include "lpd_map.svh"
module lpd_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clock_true_input,
    input wire logic dq_oe,
    input wire logic strobe_oe,
    input wire logic strobe_true_out,
    input wire logic strobe_comp_out,
    input wire logic [`LPD_BANKS-1:0] partial_array_self_refresh,
    input wire logic [`LPD_BANKS-1:0] bank_open,
    input wire logic [`LPD_BANKS-1:0] banks_retained,
    input wire logic in_power_down,
    input wire logic in_self_refresh,
    input wire logic in_deep_sleep,
    input wire logic refresh_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic asleep;
    logic lost;
    assign asleep = in_power_down | in_self_refresh | in_deep_sleep;
    assign lost = in_self_refresh | in_deep_sleep;
    // ==========================================================
    // Assertions
    chk_oe_pair: assert property (dq_oe == strobe_oe)
        else $error("data and strobe drive enables differ");
    chk_comp_inverse: assert property (strobe_comp_out == !strobe_true_out)
        else $error("strobe complement is not the inverse");
    chk_one_state: assert property (
        $onehot0({in_power_down, in_self_refresh, in_deep_sleep}))
        else $error("more than one power state at once");
    chk_sleep_quiet: assert property (asleep [*2] |-> !dq_oe && !strobe_oe)
        else $error("drivers enabled while clock enable is low");
    chk_deep_closed: assert property (
        in_deep_sleep [*2] |-> bank_open == 4'h0 && banks_retained == 4'h0)
        else $error("deep sleep left banks open or retained");
    chk_sref_mask: assert property (
        in_self_refresh [*2] |-> banks_retained == ~partial_array_self_refresh)
        else $error("self refresh retention differs from bank mask");
    chk_awake_kept: assert property ((!lost) [*2] |-> banks_retained == 4'hf)
        else $error("banks not all retained while awake");
    chk_refresh_closed: assert property (
        refresh_done |-> bank_open == 4'h0 ##1 !refresh_done)
        else $error("refresh done with a bank open or held");
    // The pin runs ahead of the synchronised copy, so look back past the capture delay
    chk_open_after_fall: assert property (
        (bank_open & ~$past(bank_open)) != 4'h0 |-> !$past(clock_true_input, 2))
        else $error("row opened before the falling half of the command");
    cov_read: cover property ($rose(dq_oe));
    cov_refresh: cover property (refresh_done);
    cov_sref: cover property (in_self_refresh);
    cov_deep: cover property (in_deep_sleep);
endmodule : lpd_sva

// ### bench/lpd_host.sv
// Memory controller model: link clock, command frames, write strobes and read capture
`timescale 1ns/1ps
module lpd_host (
    input wire logic sys_clk,
    input wire logic [15:0] dq_out,
    input wire logic strobe_true_out,
    input wire logic strobe_oe,
    output logic ck_t,
    output logic ck_c,
    output logic cs_n,
    output logic cke,
    output logic [9:0] ca,
    output logic [15:0] dq,
    output logic dqs_t,
    output logic [1:0] dm
);
    logic [15:0] rd_q [$];
    logic last_s;
    initial begin
        ck_t = 1'b0;
        ck_c = 1'b1;
        cs_n = 1'b1;
        cke = 1'b1;
        ca = 10'h000;
        dq = 16'h0000;
        dqs_t = 1'b0;
        dm = 2'h0;
    end
    // ==========================================================
    // Read capture: every strobe change while driven is one beat
    always @(posedge sys_clk) begin
        if (strobe_oe && strobe_true_out != last_s) rd_q.push_back(dq_out);
        last_s <= strobe_true_out;
    end
    // ==========================================================
    // Link drive: CA moves one cycle before each edge so the synchroniser sees it settled
    task automatic edge_to(input logic lvl, input logic [9:0] nca, input logic ncs_n);
        ck_t <= lvl;
        ck_c <= ~lvl;
        repeat (4) @(posedge sys_clk);
        ca <= nca;
        cs_n <= ncs_n;
        @(posedge sys_clk);
    endtask : edge_to
    // Clock stops low after each frame; the device has to ride through the pause
    task automatic cmd(input logic csn, input logic [9:0] r, input logic [9:0] f);
        ca <= r;
        cs_n <= csn;
        @(posedge sys_clk);
        edge_to(1'b1, f, csn);
        edge_to(1'b0, ~f, 1'b1);
    endtask : cmd
    task automatic cke_to(input logic lvl, input logic csn, input logic [9:0] r);
        ca <= r;
        cs_n <= csn;
        cke <= lvl;
        @(posedge sys_clk);
        edge_to(1'b1, ~r, 1'b1);
        edge_to(1'b0, r, 1'b1);
    endtask : cke_to
    task automatic run(input int cycles);
        repeat (cycles) begin
            edge_to(1'b1, ~ca, 1'b1);
            edge_to(1'b0, ~ca, 1'b1);
        end
    endtask : run
    task automatic wr(input int beats, input logic [15:0] base, input logic [1:0] m);
        for (int i = 0; i < beats; i++) begin
            dq <= base + 16'(i);
            dm <= m;
            repeat (3) @(posedge sys_clk);
            dqs_t <= ~dqs_t;
            repeat (5) @(posedge sys_clk);
        end
        dq <= ~dq;
        dm <= ~m;
    endtask : wr
endmodule : lpd_host

// ### bench/test_lpd_device.sv
// Top bench for the device end: bursts, precharge, refresh and power states
`timescale 1ns/1ps
`include "lpd_map.svh"
module test_lpd_device;
    logic sys_clk, rst, clock_true_input, clock_complement_input, cs_n, cke, dqs_t, s_w;
    logic dq_oe, strobe_true_out, strobe_comp_out, strobe_oe, refresh_done;
    logic in_power_down, in_self_refresh, in_deep_sleep;
    logic [9:0] cmd_addr_bus;
    logic [15:0] hdq, dq_out, dq_w;
    logic [1:0] write_byte_mask, burst_len_code, b;
    logic [3:0] read_delay_cycles, write_delay_cycles, partial_array_self_refresh;
    logic [3:0] bank_open, banks_retained;
    logic [15:0] mem [256];
    int n, errors, tests_run, refreshes;
    assign dq_w = dq_oe ? dq_out : hdq;
    assign s_w = strobe_oe ? strobe_true_out : dqs_t;
    lpd_device dut (.sys_clk, .rst, .clock_true_input, .clock_complement_input, .cs_n, .cke,
        .cmd_addr_bus, .dq_in(dq_w), .dq_out, .dq_oe, .strobe_true_in(s_w),
        .strobe_comp_in(~s_w), .strobe_true_out, .strobe_comp_out, .strobe_oe,
        .write_byte_mask, .burst_len_code, .read_delay_cycles, .write_delay_cycles,
        .partial_array_self_refresh, .bank_open, .banks_retained, .in_power_down,
        .in_self_refresh, .in_deep_sleep, .refresh_done);
    lpd_host h (.sys_clk, .dq_out, .strobe_true_out, .strobe_oe, .ck_t(clock_true_input),
        .ck_c(clock_complement_input), .cs_n, .cke, .ca(cmd_addr_bus), .dq(hdq), .dqs_t,
        .dm(write_byte_mask));
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (refresh_done === 1'b1) refreshes++;
    // ==========================================================
    // Helpers
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask : settle
    // Bursts start at column 6 and wrap inside the burst length
    function automatic int idx(input int i);
        return b * 64 + 32 + ((6 & ~(n - 1)) | ((6 + i) & (n - 1)));
    endfunction : idx
    task automatic wr_burst(input logic [15:0] base, input logic [1:0] m);
        h.cmd(1'b0, {4'h0, b, 4'h2}, 10'h003);
        h.run(int'(write_delay_cycles));
        h.wr(n, base, m);
        for (int i = 0; i < n; i++) begin
            if (!m[0]) mem[idx(i)][7:0] = base[7:0] + 8'(i);
            if (!m[1]) mem[idx(i)][15:8] = base[15:8];
        end
        h.run(2);
    endtask : wr_burst
    task automatic rd_burst(input logic [3:0] op);
        h.rd_q.delete();
        h.cmd(1'b0, {4'h0, b, op}, 10'h003);
        h.run(int'(read_delay_cycles) + n / 2 + 2);
        check(h.rd_q.size() == n, "read beat count");
        for (int i = 0; i < n; i++) check(h.rd_q[i] === mem[idx(i)], "read data");
    endtask : rd_burst
    // ==========================================================
    // Main sequence
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        burst_len_code = 2'h1;
        read_delay_cycles = 4'h2;
        write_delay_cycles = 4'h1;
        partial_array_self_refresh = 4'h5;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check(bank_open === 4'h0 && banks_retained === 4'hf && dq_oe === 1'b0, "reset state");
        for (int k = 1; k < 4; k++) begin
            n = 2 << k;
            b = 2'(k);
            burst_len_code <= 2'(k);
            read_delay_cycles <= 4'(k + 2);
            write_delay_cycles <= 4'(k);
            h.cmd(1'b0, {4'h0, b, 4'h1}, 10'h002);
            settle();
            check(bank_open === 4'(1 << k), "activate opens one bank");
            wr_burst(16'(k * 16'h1111), 2'h0);
            wr_burst(16'ha0a0, 2'h1);
            rd_burst(4'h4);
            rd_burst(4'h5);
            check(bank_open === 4'h0, "auto precharge closes bank");
        end
        // Write with auto precharge: the bank must close once the last beat is in
        h.cmd(1'b0, {4'h0, b, 4'h1}, 10'h002);
        h.cmd(1'b0, {4'h0, b, 4'h3}, 10'h003);
        h.run(int'(write_delay_cycles));
        h.wr(n, 16'h5a5a, 2'h0);
        h.run(2);
        check(bank_open === 4'h0, "write auto precharge closes bank");
        h.cmd(1'b1, 10'h001, 10'h002);
        settle();
        check(bank_open === 4'h0, "deselected command ignored");
        h.cmd(1'b0, 10'h001, 10'h002);
        h.cmd(1'b0, 10'h031, 10'h002);
        h.cmd(1'b0, 10'h006, 10'h000);
        settle();
        check(bank_open === 4'h8, "single bank precharge");
        h.cmd(1'b0, 10'h008, 10'h000);
        h.cmd(1'b0, 10'h007, 10'h000);
        settle();
        check(refreshes === 0 && bank_open === 4'h0, "refresh refused, all precharged");
        h.cmd(1'b0, 10'h008, 10'h000);
        settle();
        check(refreshes === 1, "all-bank refresh");
        h.cke_to(1'b0, 1'b0, 10'h009);
        check(in_self_refresh === 1'b1 && banks_retained === 4'ha, "self refresh mask");
        h.cke_to(1'b1, 1'b1, 10'h000);
        check(in_self_refresh === 1'b0 && banks_retained === 4'hf, "self refresh exit");
        h.cke_to(1'b0, 1'b1, 10'h000);
        h.cmd(1'b0, 10'h001, 10'h002);
        settle();
        check(in_power_down === 1'b1 && bank_open === 4'h0, "power down ignores");
        h.cke_to(1'b1, 1'b1, 10'h000);
        h.cmd(1'b0, 10'h021, 10'h002);
        h.cke_to(1'b0, 1'b0, 10'h00a);
        check(in_deep_sleep === 1'b1 && bank_open === 4'h0, "deep sleep entry");
        h.cke_to(1'b1, 1'b1, 10'h000);
        settle();
        check(in_deep_sleep === 1'b0 && banks_retained === 4'hf, "deep sleep exit");
        print_verdict();
    end
    // Generous bound: the whole sequence needs well under a tenth of this
    initial begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end
endmodule : test_lpd_device
bind lpd_device lpd_sva u_sva (.sys_clk, .rst, .clock_true_input, .dq_oe, .strobe_oe,
    .strobe_true_out, .strobe_comp_out, .partial_array_self_refresh, .bank_open,
    .banks_retained, .in_power_down, .in_self_refresh, .in_deep_sleep, .refresh_done);
